// ---- rtl/ath_pkg.sv ----
// constants for the atapi host task register block
package ath_pkg;
  // sub-cpu register indices on the plain register port
  localparam logic [4:0] SUB_HOST_IRQ_TRIGGER_IDX = 5'h00;
  localparam logic [4:0] SUB_STATUS_IDX = 5'h01;
  localparam logic [4:0] SUB_COMMAND_IDX = 5'h02;
  localparam logic [4:0] SUB_DEVCTL_IDX = 5'h03;
  localparam logic [4:0] SUB_DRVSEL_IDX = 5'h04;
  localparam logic [4:0] SUB_XFERCTL_IDX = 5'h05;
  localparam logic [4:0] SUB_DRVADDR_IDX = 5'h06;
  localparam logic [4:0] SUB_SECTOR_IDX = 5'h07;
  localparam logic [4:0] SUB_INTREASON_IDX = 5'h08;
  localparam logic [4:0] SUB_FEATURES_IDX = 5'h09;
  localparam logic [4:0] SUB_ERROR_IDX = 5'h0A;
  localparam logic [4:0] SUB_HOSTSEL_IDX = 5'h0B;
  localparam logic [4:0] SUB_FLAGS_IDX = 5'h0C;
  localparam logic [4:0] SUB_XFERLEN_IDX = 5'h0D;
  // host-side task register indices
  localparam logic [2:0] HOST_DATA_IDX = 3'h0;
  localparam logic [2:0] HOST_FEAT_ERR_IDX = 3'h1;
  localparam logic [2:0] HOST_INTREASON_IDX = 3'h2;
  localparam logic [2:0] HOST_SECTOR_IDX = 3'h3;
  localparam logic [2:0] HOST_DRVSEL_IDX = 3'h6;
  localparam logic [2:0] HOST_CMD_STAT_IDX = 3'h7;
  localparam logic [2:0] HOST_DEVCTL_IDX = 3'h5;
  // field positions
  localparam int BUSY_BIT = 7;
  localparam int DRV_BIT = 4;
  localparam int SRST_BIT = 2;
  localparam int BURST_BIT = 6;
  localparam int DMA_BIT = 5;
  localparam int XIRQ_EN_BIT = 4;
  localparam int REAL_DRIVE_NUMBER_BIT = 3;
  // reset values, drive select fixed ones and the diagnostic command code
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [7:0] XFERCTL_RESET = 8'h08;
  localparam logic [7:0] DRVSEL_ONES = 8'hE0;
  localparam logic [2:0] HOSTSEL_RESET = 3'h3;
  localparam logic [7:0] DIAG_CMD = 8'h90;
  // host mode codes
  localparam logic [2:0] MODE_LEGACY_A = 3'h0;
  localparam logic [2:0] MODE_ATAPI = 3'h1;
  localparam logic [2:0] MODE_LEGACY_B = 3'h2;
  // transfer limits
  localparam logic [15:0] MAX_BYTES_ATAPI = 16'hFFFF;
  localparam logic [15:0] MAX_BYTES_LEGACY = 16'h7FFF;
  localparam logic [15:0] PACKET_BYTES = 16'h000C;
  typedef enum logic [2:0] {
    ROUTE_MEM_TO_HOST,
    ROUTE_HOST_TO_MEM,
    ROUTE_SUB_TO_MEM,
    ROUTE_MEM_TO_SUB,
    ROUTE_HOST_TO_SUB,
    ROUTE_SUB_TO_HOST,
    ROUTE_RES_A,
    ROUTE_RES_B
  } ath_route_t;
endpackage

// ---- rtl/ath_task_regs.sv ----
// atapi host task registers and transfer routing control
//
// Operation
// - atapi mode: sub-cpu write to trigger register raises host interrupt
// - host interrupt drops on host status read or host command write
// - legacy host modes: trigger register write does nothing
// - status register atapi only, sub-cpu write only, host reads it
// - host command write to selected drive sets busy bit 7
// - diagnostic command 90h also sets busy
// - soft reset write and hardware reset set busy
// - status resets to 80h
// - command register atapi only, sub-cpu reads host command byte
// - command interrupt on selected-drive command write or diagnostic code
// - sub-cpu command read clears command interrupt
// - device control read-only; reading it clears soft reset interrupt
// - drive select reads ones in 7..5, host drive bit in 4
// - non-diagnostic commands, features writes and the host irq need drive bit to match real-drive bit
// - drive address, error write-only; features read-only; sector, reason kept
// - transfer control resets to zero with real-drive bit set
// - bit 6 selects single- or multi-word dma
// - bit 5 selects dma or pio; bit 4 enables local transfer irq
// - three-bit route field selects path and byte limit
// - host-to-sub-cpu is pio only, always twelve bytes
`timescale 1ns/100ps
`default_nettype none
module ath_task_regs (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic [4:0] SUB_ADDR_IN,
  input wire logic [7:0] SUB_WDATA_IN,
  input wire logic SUB_WR_IN,
  input wire logic SUB_RD_IN,
  output logic [7:0] SUB_RDATA_OUT,
  input wire logic [2:0] HOST_ADDR_IN,
  input wire logic [7:0] HOST_WDATA_IN,
  input wire logic HOST_WR_IN,
  input wire logic HOST_RD_IN,
  output logic [7:0] HOST_RDATA_OUT,
  output logic HOST_IRQ_OUT,
  output logic HOST_PINS_EN_OUT,
  output logic COMMAND_ARRIVED_IRQ_OUT,
  output logic SOFT_RESET_IRQ_OUT,
  output logic LOCAL_XFER_IRQ_OUT,
  input wire logic XFER_DONE_IN,
  output logic [2:0] TRANSFER_ROUTE_OUT,
  output logic DMA_NOT_PIO_OUT,
  output logic BURST_STYLE_OUT,
  output logic [15:0] XFER_LIMIT_OUT
);
  logic [7:0] status_reg;
  logic [7:0] command_reg;
  logic [7:0] devctl_reg;
  logic host_drive_choice_reg;
  logic [7:0] xferctl_reg;
  logic [7:0] drvaddr_reg;
  logic [7:0] sector_reg;
  logic [7:0] intreason_reg;
  logic [7:0] features_reg;
  logic [7:0] error_reg;
  logic [2:0] hostsel_reg;
  logic host_irq_reg;
  logic cmd_irq_reg;
  logic srst_irq_reg;
  logic xfer_irq_reg;
  logic [15:0] limit_next;
  logic [7:0] sub_rdata_next;
  logic [7:0] host_rdata_next;

  // decoded strobes
  logic atapi_mode;
  logic selected;
  logic sub_wr_host_irq_trigger, sub_wr_status, sub_rd_cmd, sub_rd_devctl;
  logic host_wr_cmd, host_rd_stat, host_wr_devctl, host_wr_drvsel;
  logic cmd_accept, srst_write;

  function automatic logic sub_hit(input logic [4:0] a, input logic [4:0] idx);
    sub_hit = (a == idx);
  endfunction

  assign atapi_mode = (hostsel_reg == ath_pkg::MODE_ATAPI);
  assign selected = (host_drive_choice_reg == xferctl_reg[ath_pkg::REAL_DRIVE_NUMBER_BIT]);
  assign sub_wr_host_irq_trigger = SUB_WR_IN && sub_hit(SUB_ADDR_IN, ath_pkg::SUB_HOST_IRQ_TRIGGER_IDX);
  assign sub_wr_status = SUB_WR_IN && sub_hit(SUB_ADDR_IN, ath_pkg::SUB_STATUS_IDX) && atapi_mode;
  assign sub_rd_cmd = SUB_RD_IN && sub_hit(SUB_ADDR_IN, ath_pkg::SUB_COMMAND_IDX);
  assign sub_rd_devctl = SUB_RD_IN && sub_hit(SUB_ADDR_IN, ath_pkg::SUB_DEVCTL_IDX);
  // host task accesses only count while the atapi host port is live
  assign host_wr_cmd = atapi_mode && HOST_WR_IN && (HOST_ADDR_IN == ath_pkg::HOST_CMD_STAT_IDX);
  assign host_rd_stat = atapi_mode && HOST_RD_IN && (HOST_ADDR_IN == ath_pkg::HOST_CMD_STAT_IDX);
  assign host_wr_devctl = atapi_mode && HOST_WR_IN && (HOST_ADDR_IN == ath_pkg::HOST_DEVCTL_IDX);
  assign host_wr_drvsel = atapi_mode && HOST_WR_IN && (HOST_ADDR_IN == ath_pkg::HOST_DRVSEL_IDX);
  // accepted command: selected drive, or diagnostic code reaching both drives
  assign cmd_accept = host_wr_cmd && (selected || HOST_WDATA_IN == ath_pkg::DIAG_CMD);
  assign srst_write = host_wr_devctl && HOST_WDATA_IN[ath_pkg::SRST_BIT];

  // host mode select, software owned
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      hostsel_reg <= ath_pkg::HOSTSEL_RESET;
    end else if (SUB_WR_IN && sub_hit(SUB_ADDR_IN, ath_pkg::SUB_HOSTSEL_IDX)) begin
      hostsel_reg <= SUB_WDATA_IN[2:0];
    end
  end

  // status register; hardware busy setting wins over a same-cycle software write
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      status_reg <= ath_pkg::STATUS_RESET;
    end else begin
      if (sub_wr_status) begin
        status_reg <= SUB_WDATA_IN;
      end
      if (cmd_accept || srst_write) begin
        status_reg[ath_pkg::BUSY_BIT] <= 1'b1;
      end
    end
  end

  // host-written task registers
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      command_reg <= 8'h00;
      devctl_reg <= 8'h00;
      host_drive_choice_reg <= 1'b0;
      features_reg <= 8'h00;
    end else begin
      if (cmd_accept) begin
        command_reg <= HOST_WDATA_IN;
      end
      if (host_wr_devctl) begin
        devctl_reg <= HOST_WDATA_IN;
      end
      if (host_wr_drvsel) begin
        host_drive_choice_reg <= HOST_WDATA_IN[ath_pkg::DRV_BIT];
      end
      if (atapi_mode && HOST_WR_IN && HOST_ADDR_IN == ath_pkg::HOST_FEAT_ERR_IDX && selected) begin
        features_reg <= HOST_WDATA_IN;
      end
    end
  end

  // sub-cpu written task registers
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      drvaddr_reg <= 8'h00;
      sector_reg <= 8'h00;
      intreason_reg <= 8'h00;
      error_reg <= 8'h00;
    end else if (SUB_WR_IN) begin
      if (sub_hit(SUB_ADDR_IN, ath_pkg::SUB_DRVADDR_IDX)) drvaddr_reg <= SUB_WDATA_IN;
      if (sub_hit(SUB_ADDR_IN, ath_pkg::SUB_SECTOR_IDX)) sector_reg <= SUB_WDATA_IN;
      if (sub_hit(SUB_ADDR_IN, ath_pkg::SUB_INTREASON_IDX)) intreason_reg <= SUB_WDATA_IN;
      if (sub_hit(SUB_ADDR_IN, ath_pkg::SUB_ERROR_IDX)) error_reg <= SUB_WDATA_IN;
    end
  end

  // transfer control; reserved bit 7 stays zero
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      xferctl_reg <= ath_pkg::XFERCTL_RESET;
    end else if (SUB_WR_IN && sub_hit(SUB_ADDR_IN, ath_pkg::SUB_XFERCTL_IDX)) begin
      xferctl_reg <= {1'b0, SUB_WDATA_IN[6:0]};
    end
  end

  // host interrupt: set wins over a same-cycle host clear
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      host_irq_reg <= 1'b0;
    end else if (sub_wr_host_irq_trigger && atapi_mode) begin
      host_irq_reg <= 1'b1;
    end else if (host_rd_stat || host_wr_cmd || !atapi_mode) begin
      host_irq_reg <= 1'b0;
    end
  end

  // sub-cpu interrupts: set wins over read clear
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      cmd_irq_reg <= 1'b0;
      srst_irq_reg <= 1'b0;
      xfer_irq_reg <= 1'b0;
    end else begin
      if (cmd_accept) begin
        cmd_irq_reg <= 1'b1;
      end else if (sub_rd_cmd) begin
        cmd_irq_reg <= 1'b0;
      end
      if (srst_write) begin
        srst_irq_reg <= 1'b1;
      end else if (sub_rd_devctl) begin
        srst_irq_reg <= 1'b0;
      end
      if (XFER_DONE_IN && xferctl_reg[ath_pkg::XIRQ_EN_BIT]) begin
        xfer_irq_reg <= 1'b1;
      end else if (SUB_RD_IN && sub_hit(SUB_ADDR_IN, ath_pkg::SUB_FLAGS_IDX)) begin
        xfer_irq_reg <= 1'b0;
      end
    end
  end

  // byte limit of the selected route
  always_comb begin
    case (ath_pkg::ath_route_t'(xferctl_reg[2:0]))
      ath_pkg::ROUTE_MEM_TO_HOST, ath_pkg::ROUTE_HOST_TO_MEM: begin
        limit_next = atapi_mode ? ath_pkg::MAX_BYTES_ATAPI : ath_pkg::MAX_BYTES_LEGACY;
      end
      ath_pkg::ROUTE_HOST_TO_SUB, ath_pkg::ROUTE_SUB_TO_HOST: begin
        limit_next = ath_pkg::PACKET_BYTES;
      end
      default: begin
        limit_next = 16'h0000; // no host-side limit or reserved
      end
    endcase
  end

  // sub-cpu read mux; write-only registers read as zero
  always_comb begin
    sub_rdata_next = 8'h00;
    case (SUB_ADDR_IN)
      ath_pkg::SUB_COMMAND_IDX: sub_rdata_next = atapi_mode ? command_reg : 8'h00;
      ath_pkg::SUB_DEVCTL_IDX: sub_rdata_next = devctl_reg;
      ath_pkg::SUB_DRVSEL_IDX: sub_rdata_next = ath_pkg::DRVSEL_ONES | {3'h0, host_drive_choice_reg, 4'h0};
      ath_pkg::SUB_XFERCTL_IDX: sub_rdata_next = xferctl_reg;
      ath_pkg::SUB_SECTOR_IDX: sub_rdata_next = sector_reg;
      ath_pkg::SUB_INTREASON_IDX: sub_rdata_next = intreason_reg;
      ath_pkg::SUB_FEATURES_IDX: sub_rdata_next = features_reg;
      ath_pkg::SUB_HOSTSEL_IDX: sub_rdata_next = {5'h00, hostsel_reg};
      ath_pkg::SUB_FLAGS_IDX: sub_rdata_next = {4'h0, xfer_irq_reg, srst_irq_reg, cmd_irq_reg, host_irq_reg};
      default: sub_rdata_next = 8'h00;
    endcase
  end

  // host read mux; the host sees what the sub-cpu posted
  always_comb begin
    host_rdata_next = 8'h00;
    case (HOST_ADDR_IN)
      ath_pkg::HOST_CMD_STAT_IDX: host_rdata_next = status_reg;
      ath_pkg::HOST_FEAT_ERR_IDX: host_rdata_next = error_reg;
      ath_pkg::HOST_INTREASON_IDX: host_rdata_next = intreason_reg;
      ath_pkg::HOST_SECTOR_IDX: host_rdata_next = sector_reg;
      ath_pkg::HOST_DRVSEL_IDX: host_rdata_next = drvaddr_reg;
      default: host_rdata_next = 8'h00;
    endcase
  end

  // registered outputs
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      SUB_RDATA_OUT <= 8'h00;
      HOST_RDATA_OUT <= 8'h00;
      XFER_LIMIT_OUT <= 16'h0000;
    end else begin
      SUB_RDATA_OUT <= SUB_RD_IN ? sub_rdata_next : 8'h00;
      HOST_RDATA_OUT <= (HOST_RD_IN && atapi_mode) ? host_rdata_next : 8'h00;
      XFER_LIMIT_OUT <= limit_next;
    end
  end

  // pin-level controls; host-to-sub route forces pio
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      TRANSFER_ROUTE_OUT <= 3'h0;
      DMA_NOT_PIO_OUT <= 1'b0;
      BURST_STYLE_OUT <= 1'b0;
      HOST_PINS_EN_OUT <= 1'b0;
      HOST_IRQ_OUT <= 1'b0;
      COMMAND_ARRIVED_IRQ_OUT <= 1'b0;
      SOFT_RESET_IRQ_OUT <= 1'b0;
      LOCAL_XFER_IRQ_OUT <= 1'b0;
    end else begin
      TRANSFER_ROUTE_OUT <= xferctl_reg[2:0];
      DMA_NOT_PIO_OUT <= xferctl_reg[ath_pkg::DMA_BIT] &&
        (xferctl_reg[2:0] != 3'(ath_pkg::ROUTE_HOST_TO_SUB));
      BURST_STYLE_OUT <= xferctl_reg[ath_pkg::BURST_BIT];
      HOST_PINS_EN_OUT <= (hostsel_reg == ath_pkg::MODE_ATAPI) || (hostsel_reg == ath_pkg::MODE_LEGACY_A) ||
        (hostsel_reg == ath_pkg::MODE_LEGACY_B);
      HOST_IRQ_OUT <= host_irq_reg && selected;
      COMMAND_ARRIVED_IRQ_OUT <= cmd_irq_reg;
      SOFT_RESET_IRQ_OUT <= srst_irq_reg;
      LOCAL_XFER_IRQ_OUT <= xfer_irq_reg;
    end
  end

  // checks
  a_host_irq_trigger_raises_irq: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    sub_wr_host_irq_trigger && atapi_mode |=> host_irq_reg) else $error("trigger write lost");
  a_host_irq_clear: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    host_rd_stat && !sub_wr_host_irq_trigger |=> !host_irq_reg) else $error("host irq not cleared");
  a_legacy_no_irq: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    !atapi_mode |=> !host_irq_reg) else $error("legacy mode irq");
  a_busy_on_cmd: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    cmd_accept |=> status_reg[ath_pkg::BUSY_BIT] && cmd_irq_reg)
    else $error("busy or cmd irq missing");
  a_diag_busy: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    host_wr_cmd && HOST_WDATA_IN == ath_pkg::DIAG_CMD |=> status_reg[ath_pkg::BUSY_BIT])
    else $error("diag busy");
  a_srst_busy: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    srst_write |=> status_reg[ath_pkg::BUSY_BIT] && srst_irq_reg) else $error("soft reset busy");
  a_reset_values: assert property (@(posedge CLOCK_IN)
    RST_IN |=> status_reg == ath_pkg::STATUS_RESET && xferctl_reg == ath_pkg::XFERCTL_RESET)
    else $error("reset value");
  a_cmd_irq_clear: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    sub_rd_cmd && !cmd_accept |=> !cmd_irq_reg ##1 !COMMAND_ARRIVED_IRQ_OUT) else $error("cmd irq stuck");
  a_srst_irq_clear: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    sub_rd_devctl && !srst_write |=> !srst_irq_reg) else $error("srst irq stuck");
  a_packet_limit: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    xferctl_reg[2:0] == 3'(ath_pkg::ROUTE_HOST_TO_SUB) |=> XFER_LIMIT_OUT == ath_pkg::PACKET_BYTES &&
    !DMA_NOT_PIO_OUT) else $error("packet limit");

  // trigger path in steps: write seen, flag next cycle, pin the cycle after
  // a drive-select write in the same cycle would change the gate, so it is excluded
  sequence s_trig_write;
    sub_wr_host_irq_trigger && atapi_mode && selected && !host_wr_drvsel;
  endsequence
  sequence s_trig_answer;
    host_irq_reg ##1 HOST_IRQ_OUT;
  endsequence

  // command path in steps: accepted write, busy and flag, then the pin
  sequence s_cmd_write;
    cmd_accept;
  endsequence
  sequence s_cmd_answer;
    cmd_irq_reg && status_reg[ath_pkg::BUSY_BIT] ##1 COMMAND_ARRIVED_IRQ_OUT;
  endsequence

  // soft reset path in steps
  sequence s_srst_answer;
    srst_irq_reg ##1 SOFT_RESET_IRQ_OUT;
  endsequence

  // host interrupt pin follows the trigger two cycles later
  a_trig_pin_walk: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    s_trig_write |=> s_trig_answer) else $error("host irq pin late");

  // command interrupt pin follows an accepted command two cycles later
  a_cmd_pin_walk: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    s_cmd_write |=> s_cmd_answer) else $error("cmd irq pin late");

  // soft reset interrupt pin follows the device control write
  a_srst_pin_walk: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    srst_write |=> s_srst_answer) else $error("srst irq pin late");

  // drive select reads ones on top and the host drive bit below
  a_drvsel_read: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    SUB_RD_IN && SUB_ADDR_IN == ath_pkg::SUB_DRVSEL_IDX |=>
    (SUB_RDATA_OUT & ath_pkg::DRVSEL_ONES) == ath_pkg::DRVSEL_ONES &&
    SUB_RDATA_OUT[ath_pkg::DRV_BIT] == $past(host_drive_choice_reg)) else $error("drive select read");

  // features cannot be written from the sub-cpu side
  a_features_ro: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    SUB_WR_IN && SUB_ADDR_IN == ath_pkg::SUB_FEATURES_IDX && !HOST_WR_IN |=> $stable(features_reg))
    else $error("features written by sub-cpu");

  // status writes outside atapi mode are dropped
  a_status_refused: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    SUB_WR_IN && SUB_ADDR_IN == ath_pkg::SUB_STATUS_IDX && !atapi_mode |=> $stable(status_reg))
    else $error("status written outside atapi");

  // a deselected drive never shows a host interrupt
  a_irq_gated: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    !selected |=> !HOST_IRQ_OUT) else $error("irq from deselected drive");

  // unknown host mode keeps the host pins released
  a_pins_float: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    hostsel_reg == ath_pkg::HOSTSEL_RESET |=> !HOST_PINS_EN_OUT) else $error("pins driven");

  // host reads outside atapi mode return zero
  a_host_read_refused: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    HOST_RD_IN && !atapi_mode |=> HOST_RDATA_OUT == 8'h00) else $error("host read outside atapi");

  // dma bit reaches the pin on every route but host-to-sub
  a_dma_route: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    xferctl_reg[ath_pkg::DMA_BIT] && xferctl_reg[2:0] != 3'(ath_pkg::ROUTE_HOST_TO_SUB) |=>
    DMA_NOT_PIO_OUT) else $error("dma select lost");

  // legacy modes cap the memory/host routes lower
  a_legacy_limit: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    !atapi_mode && xferctl_reg[2:1] == 2'h0 |=> XFER_LIMIT_OUT == ath_pkg::MAX_BYTES_LEGACY)
    else $error("legacy limit");

  // an enabled transfer-done event raises the local flag
  a_xfer_irq_set: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    XFER_DONE_IN && xferctl_reg[ath_pkg::XIRQ_EN_BIT] |=> xfer_irq_reg) else $error("xfer irq lost");
endmodule
`default_nettype wire

// ---- test/ath_host_model.sv ----
// behavioural atapi host that drives the task register port
`timescale 1ns/100ps
`default_nettype none
module ath_host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [2:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  // idle bus at time zero
  initial begin
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // one-cycle host write strobe
  task automatic hw(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d; // released data lines: inverse so stale data never looks fresh
  endtask
  // one-cycle host read strobe, data taken in the following cycle
  task automatic hr(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule
`default_nettype wire

// ---- test/ath_task_regs_tb_top.sv ----
// self-checking bench for the atapi host task register block
`timescale 1ns/100ps
`default_nettype none
module ath_task_regs_tb_top;
  logic clk, rst, sub_wr, sub_rd, xfer_done;
  logic [4:0] sub_addr;
  logic [7:0] sub_wd, sub_rdata, host_rdata, h_wd;
  logic [2:0] h_addr;
  logic h_wr, h_rd, host_irq, pins_en, cmd_irq, srst_irq, xfer_irq, dma, burst;
  logic [2:0] route;
  logic [15:0] limit;
  int mismatches, n_checks;
  logic [7:0] d;
  logic [2:0] r;
  ath_host_model host (.clk(clk), .rdata(host_rdata), .addr(h_addr), .wdata(h_wd), .wr(h_wr), .rd(h_rd));
  ath_task_regs uut (.CLOCK_IN(clk), .RST_IN(rst), .SUB_ADDR_IN(sub_addr), .SUB_WDATA_IN(sub_wd),
    .SUB_WR_IN(sub_wr), .SUB_RD_IN(sub_rd), .SUB_RDATA_OUT(sub_rdata), .HOST_ADDR_IN(h_addr),
    .HOST_WDATA_IN(h_wd), .HOST_WR_IN(h_wr), .HOST_RD_IN(h_rd), .HOST_RDATA_OUT(host_rdata),
    .HOST_IRQ_OUT(host_irq), .HOST_PINS_EN_OUT(pins_en), .COMMAND_ARRIVED_IRQ_OUT(cmd_irq),
    .SOFT_RESET_IRQ_OUT(srst_irq), .LOCAL_XFER_IRQ_OUT(xfer_irq), .XFER_DONE_IN(xfer_done),
    .TRANSFER_ROUTE_OUT(route), .DMA_NOT_PIO_OUT(dma), .BURST_STYLE_OUT(burst), .XFER_LIMIT_OUT(limit));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sw(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    sub_addr <= a;
    sub_wd <= v;
    sub_wr <= 1'b1;
    @(posedge clk);
    sub_wr <= 1'b0;
  endtask
  task automatic srchk(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    sub_addr <= a;
    sub_rd <= 1'b1;
    @(posedge clk);
    sub_rd <= 1'b0;
    #1;
    chk(sub_rdata, e);
  endtask
  task automatic hrchk(input logic [2:0] a, input logic [7:0] e);
    host.hr(a, d);
    chk(d, e);
  endtask
  // irq outputs lag their cause by two cycles, so three covers them
  task automatic wt();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic done_pulse();
    @(posedge clk);
    xfer_done <= 1'b1;
    @(posedge clk);
    xfer_done <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    {sub_wr, sub_rd, xfer_done} = 3'h0;
    sub_addr = 5'h00;
    sub_wd = 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // reset values and the floating host pins
    srchk(ath_pkg::SUB_XFERCTL_IDX, ath_pkg::XFERCTL_RESET);
    srchk(ath_pkg::SUB_HOSTSEL_IDX, 8'h03);
    chk(pins_en, 16'h0000);
    $display("test reset done");
    // atapi mode, this drive selected; trigger and its two clears
    sw(ath_pkg::SUB_HOSTSEL_IDX, 8'h01);
    host.hw(ath_pkg::HOST_DRVSEL_IDX, 8'h10);
    hrchk(ath_pkg::HOST_CMD_STAT_IDX, ath_pkg::STATUS_RESET);
    sw(ath_pkg::SUB_HOST_IRQ_TRIGGER_IDX, 8'h00);
    wt();
    chk(host_irq, 16'h0001);
    hrchk(ath_pkg::HOST_CMD_STAT_IDX, ath_pkg::STATUS_RESET);
    wt();
    chk(host_irq, 16'h0000);
    sw(ath_pkg::SUB_HOST_IRQ_TRIGGER_IDX, 8'h00);
    sw(ath_pkg::SUB_STATUS_IDX, 8'h00);
    host.hw(ath_pkg::HOST_CMD_STAT_IDX, 8'hA0);
    wt();
    chk(host_irq, 16'h0000);
    chk(cmd_irq, 16'h0001);
    hrchk(ath_pkg::HOST_CMD_STAT_IDX, 8'h80);
    srchk(ath_pkg::SUB_COMMAND_IDX, 8'hA0);
    wt();
    chk(cmd_irq, 16'h0000);
    $display("test trigger and command done");
    // other drive selected: only the diagnostic code gets through
    host.hw(ath_pkg::HOST_DRVSEL_IDX, 8'h00);
    srchk(ath_pkg::SUB_DRVSEL_IDX, ath_pkg::DRVSEL_ONES);
    host.hw(ath_pkg::HOST_CMD_STAT_IDX, 8'h12);
    wt();
    chk(cmd_irq, 16'h0000);
    host.hw(ath_pkg::HOST_CMD_STAT_IDX, ath_pkg::DIAG_CMD);
    sw(ath_pkg::SUB_HOST_IRQ_TRIGGER_IDX, 8'h00);
    wt();
    chk(cmd_irq, 16'h0001);
    chk(host_irq, 16'h0000);
    srchk(ath_pkg::SUB_COMMAND_IDX, ath_pkg::DIAG_CMD);
    host.hw(ath_pkg::HOST_DRVSEL_IDX, 8'h10);
    srchk(ath_pkg::SUB_DRVSEL_IDX, 8'hF0);
    wt();
    chk(host_irq, 16'h0001);
    hrchk(ath_pkg::HOST_CMD_STAT_IDX, 8'h80);
    $display("test drive select done");
    // soft reset through device control
    sw(ath_pkg::SUB_STATUS_IDX, 8'h00);
    host.hw(ath_pkg::HOST_DEVCTL_IDX, 8'h04);
    wt();
    chk(srst_irq, 16'h0001);
    hrchk(ath_pkg::HOST_CMD_STAT_IDX, 8'h80);
    srchk(ath_pkg::SUB_DEVCTL_IDX, 8'h04);
    wt();
    chk(srst_irq, 16'h0000);
    $display("test soft reset done");
    // plain task registers both ways, and an unmapped index
    sw(ath_pkg::SUB_DRVADDR_IDX, 8'h5A);
    hrchk(ath_pkg::HOST_DRVSEL_IDX, 8'h5A);
    host.hw(ath_pkg::HOST_FEAT_ERR_IDX, 8'h33);
    srchk(ath_pkg::SUB_FEATURES_IDX, 8'h33);
    sw(ath_pkg::SUB_ERROR_IDX, 8'h44);
    hrchk(ath_pkg::HOST_FEAT_ERR_IDX, 8'h44);
    sw(ath_pkg::SUB_SECTOR_IDX, 8'h21);
    hrchk(ath_pkg::HOST_SECTOR_IDX, 8'h21);
    sw(ath_pkg::SUB_INTREASON_IDX, 8'h02);
    hrchk(ath_pkg::HOST_INTREASON_IDX, 8'h02);
    srchk(5'h1F, 8'h00);
    $display("test task registers done");
    // every route code, with burst and dma bits varied alongside
    for (int i = 0; i < 8; i++) begin
      r = i[2:0];
      sw(ath_pkg::SUB_XFERCTL_IDX, {1'b0, r[0], r[1], 2'b01, r});
      wt();
      chk(route, r);
      chk(dma, r[1]);
      chk(burst, r[0]);
      chk(limit, (r < 3'h2) ? 16'hFFFF : ((r == 3'h4 || r == 3'h5) ? 16'h000C : 16'h0000));
      srchk(ath_pkg::SUB_XFERCTL_IDX, {1'b0, r[0], r[1], 2'b01, r});
    end
    // local transfer interrupt enabled, cleared by flag read, then disabled
    sw(ath_pkg::SUB_XFERCTL_IDX, 8'h18);
    done_pulse();
    wt();
    chk(xfer_irq, 16'h0001);
    srchk(ath_pkg::SUB_FLAGS_IDX, 8'h08);
    wt();
    chk(xfer_irq, 16'h0000);
    sw(ath_pkg::SUB_XFERCTL_IDX, 8'h08);
    done_pulse();
    wt();
    chk(xfer_irq, 16'h0000);
    $display("test transfer control done");
    // both legacy modes: shorter limit, trigger has no effect
    sw(ath_pkg::SUB_HOSTSEL_IDX, 8'h00);
    sw(ath_pkg::SUB_HOST_IRQ_TRIGGER_IDX, 8'h00);
    wt();
    chk(limit, 16'h7FFF);
    chk(pins_en, 16'h0001);
    chk(host_irq, 16'h0000);
    sw(ath_pkg::SUB_HOSTSEL_IDX, 8'h02);
    sw(ath_pkg::SUB_XFERCTL_IDX, 8'h09);
    sw(ath_pkg::SUB_HOST_IRQ_TRIGGER_IDX, 8'h00);
    wt();
    chk(host_irq, 16'h0000);
    chk(limit, 16'h7FFF);
    hrchk(ath_pkg::HOST_CMD_STAT_IDX, 8'h00);
    $display("test legacy modes done");
    end_of_test();
  end
endmodule
`default_nettype wire
